// ===== common/fault_mon_regs.svh
// Register offsets, field positions, thresholds and timing constants of the fault monitor
`ifndef FAULT_MON_REGS_SVH
`define FAULT_MON_REGS_SVH
// Register byte offsets
`define CTRL_OFS 8'h00
`define STATUS_OFS 8'h04
`define CODE_OFS 8'h08
// Control register fields and reset value
`define CTRL_WARMUP_BIT 0
`define CTRL_STANDBY_BIT 1
`define CTRL_CUSTOM_BIT 2
`define CTRL_RESET 3'h0
// Fuser temperature thresholds in degrees C
`define FUSER_LOW_DEGC 8'd125
`define FUSER_HIGH_DEGC 8'd220
`define FUSER_TARGET_DEGC 8'd180
// Clock rate and times in milliseconds
`define CLK_KHZ 10000
`define MOTOR_MS 1300
`define WARMUP_MS 110000
`define HEATER_MS 10000
`define LASER_MS 50
`define FAN_GRACE_MS 3000
`define EXIT_ON_MS 2000
`define CUSTOM_MS 2000
`define REG_MS 1500
// Beam-detect spacing limits in clock cycles
`define BD_TARGET_CYC 200
`define BD_LIMIT_CYC 260
`define BD_START_CYC 4000
`endif

// ===== common/fault_mon_pkg.sv
// Types shared by the fault monitor files
package fault_mon_pkg;
    // Cause code shown to the controller
    typedef enum logic [4:0] {
        CODE_NONE = 5'h00,
        CODE_MAIN_MOTOR = 5'h01,
        CODE_SCANNER = 5'h02,
        CODE_FUSER = 5'h04,
        CODE_FAN = 5'h05,
        CODE_MEMORY = 5'h06,
        CODE_COVER = 5'h10,
        CODE_EXIT_STD = 5'h11,
        CODE_EXIT_CUSTOM = 5'h12,
        CODE_REG_TO_EXIT = 5'h13,
        CODE_REG_STUCK = 5'h14
    } fault_code_t;
    // Drive shutdown sequence after a fatal fault
    typedef enum logic [1:0] {
        RUN_S = 2'b00,
        DRAIN_S = 2'b01,
        HALT_S = 2'b10
    } stop_state_t;
endpackage

// ===== design/check_timer.sv
// Saturating timeout counter: flags when its run input has stayed high for LIMIT cycles
`timescale 1ns/100ps
`default_nettype none
module check_timer #(
    parameter int unsigned LIMIT = 10
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic run_i,
    output logic expired_o
);
    logic [31:0] cnt_r; // Cycles spent running

    // Count while run is high; a drop restarts the wait from zero
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= 32'h0;
            expired_o <= 1'b0;
        end else if (!run_i) begin
            cnt_r <= 32'h0;
            expired_o <= 1'b0;
        end else if (cnt_r == LIMIT - 1) begin
            expired_o <= 1'b1; // Counter holds here, so it never wraps
        end else begin
            cnt_r <= cnt_r + 32'h1;
        end
    end
endmodule
`default_nettype wire

// ===== design/fault_monitor.sv
// Engine fault supervisor: fatal unit faults, cover and jam codes, drive shutdown, APB
//
// Function
// - Motor slow and not ready after 1.3 s
// - Fatal fault stops drives after print cycle
// - Fatal fault latched until power cycle
// - Scanner startup beam spacing over limit faults
// - Locked beam spacing over limit faults
// - Laser power short of level faults scanner
// - Fuser not at target within 110 s
// - Printing fuser below 125 C faults
// - Fuser above 220 C faults anytime
// - Disconnected thermistor faults fuser
// - Standby heater on 10 s faults
// - Fan stopped after power-on faults
// - Memory read or write failure faults
// - Task table overflow faults memory
// - Any cover open raises cover code
// - Cover or jam stops drives at once
// - Exit jam clears after cover cycle, clear path
// - Standard paper exit sensor stuck on jams
// - Exit paper at power-on or front cover close jams
// - Custom paper misses exit after registration
// - Registration to exit too slow jams
// - Registration paper at power-on or front cover close jams
`timescale 1ns/100ps
`default_nettype none
`include "fault_mon_regs.svh"
module fault_monitor #(
    parameter int unsigned MOTOR_CYC = `MOTOR_MS * `CLK_KHZ,
    parameter int unsigned WARMUP_CYC = `WARMUP_MS * `CLK_KHZ,
    parameter int unsigned HEATER_CYC = `HEATER_MS * `CLK_KHZ,
    parameter int unsigned LASER_CYC = `LASER_MS * `CLK_KHZ,
    parameter int unsigned FAN_CYC = `FAN_GRACE_MS * `CLK_KHZ,
    parameter int unsigned EXIT_CYC = `EXIT_ON_MS * `CLK_KHZ,
    parameter int unsigned CUSTOM_CYC = `CUSTOM_MS * `CLK_KHZ,
    parameter int unsigned REG_CYC = `REG_MS * `CLK_KHZ,
    parameter int unsigned BD_TARGET = `BD_TARGET_CYC,
    parameter int unsigned BD_LIMIT = `BD_LIMIT_CYC,
    parameter int unsigned BD_START = `BD_START_CYC
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Engine sensors and requests
    input wire logic print_cycle_i,
    input wire logic engine_ready_i,
    input wire logic motor_req_i,
    input wire logic motor_at_speed_i,
    input wire logic scanner_req_i,
    input wire logic beam_detect_pulse_i,
    input wire logic laser_on_i,
    input wire logic laser_power_ok_i,
    input wire logic heater_req_i,
    input wire logic [7:0] fuser_temp_i,
    input wire logic thermistor_open_i,
    input wire logic fan_rotating_i,
    input wire logic nvm_read_fail_i,
    input wire logic nvm_write_fail_i,
    input wire logic task_overflow_i,
    input wire logic cover_front_open_i,
    input wire logic cover_rear_open_i,
    input wire logic cover_faceup_open_i,
    input wire logic reg_sensor_i,
    input wire logic exit_sensor_i,
    // Drive enables and cause code
    output logic motor_en_o,
    output logic scanner_en_o,
    output logic heater_en_o,
    output logic [4:0] code_o
);
    localparam int NT = 8; // Number of timeout checks
    localparam int unsigned LIM [NT] = '{MOTOR_CYC, LASER_CYC, WARMUP_CYC, HEATER_CYC,
                                        FAN_CYC, EXIT_CYC, CUSTOM_CYC, REG_CYC};

    logic [2:0] ctrl_r; // Warm-up, standby, custom paper
    logic [4:0] fatal_r; // Motor, scanner, fuser, fan, memory
    logic [3:0] jam_r; // Exit std, exit custom, reg to exit, reg stuck
    logic cover_r; // Some cover is open
    logic chk_r; // One-cycle check after power-on or front close
    logic front_prev_r; // Front cover open, last cycle
    logic reg_prev_r; // Registration sensor, last cycle
    logic front_seen_r; // Front opened since the jam
    logic rear_seen_r; // Rear opened since the jam
    logic custom_arm_r; // Waiting for exit after registration went off
    logic reg_arm_r; // Waiting for exit after registration came on
    logic [23:0] bd_cnt_r; // Cycles since last beam-detect pulse
    logic bd_lock_r; // Beam spacing has reached its target
    fault_mon_pkg::stop_state_t state_r;
    fault_mon_pkg::stop_state_t state_nxt;
    logic [NT-1:0] run; // Timer run conditions
    logic [NT-1:0] exp; // Timer expiries
    logic [4:0] fatal_nxt;
    logic [3:0] jam_set;
    logic clr_exit; // Cover sequence finished, paper path clear
    logic stop_now; // Immediate stop request
    logic fatal_any;
    logic any_open;
    logic apb_acc; // Access phase still waiting for the answer
    logic apb_done; // Edge at which the transfer completes

    // Timeout conditions, one per
    assign run[0] = motor_req_i && !engine_ready_i;
    assign run[1] = laser_on_i && !laser_power_ok_i;
    assign run[2] = ctrl_r[`CTRL_WARMUP_BIT] && (fuser_temp_i < `FUSER_TARGET_DEGC);
    assign run[3] = ctrl_r[`CTRL_STANDBY_BIT] && heater_en_o && heater_req_i;
    assign run[4] = 1'b1; // Fan spin-up grace after power-on
    assign run[5] = !ctrl_r[`CTRL_CUSTOM_BIT] && exit_sensor_i;
    assign run[6] = custom_arm_r && !exit_sensor_i;
    assign run[7] = reg_arm_r && !exit_sensor_i;

    // One timeout counter for each
    genvar g;
    generate
        for (g = 0; g < NT; g++) begin : g_tmr
            check_timer #(.LIMIT(LIM[g])) u_tmr (
                .clk_sys_i(clk_sys_i),
                .resetn_i(resetn_i),
                .run_i(run[g]),
                .expired_o(exp[g])
            );
        end
    endgenerate

    // Beam-detect spacing counter; saturates so a dead scanner cannot wrap it
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bd_cnt_r <= 24'h0;
            bd_lock_r <= 1'b0;
        end else if (!scanner_req_i) begin
            bd_cnt_r <= 24'h0;
            bd_lock_r <= 1'b0; // Next start is a fresh spin-up
        end else if (beam_detect_pulse_i) begin
            bd_cnt_r <= 24'h0;
            if (bd_cnt_r <= BD_TARGET) begin
                bd_lock_r <= 1'b1;
            end
        end else if (bd_cnt_r != 24'hffffff) begin
            bd_cnt_r <= bd_cnt_r + 24'h1;
        end
    end

    // New fatal causes this cycle
    always_comb begin
        fatal_nxt = 5'h0;
        fatal_nxt[0] = exp[0] && !motor_at_speed_i;
        fatal_nxt[1] = scanner_req_i && !bd_lock_r && (bd_cnt_r > BD_START);
        fatal_nxt[1] = fatal_nxt[1] || (scanner_req_i && bd_lock_r && (bd_cnt_r > BD_LIMIT));
        fatal_nxt[1] = fatal_nxt[1] || exp[1];
        fatal_nxt[2] = exp[2];
        fatal_nxt[2] = fatal_nxt[2] || (print_cycle_i && fuser_temp_i < `FUSER_LOW_DEGC);
        fatal_nxt[2] = fatal_nxt[2] || (fuser_temp_i > `FUSER_HIGH_DEGC);
        fatal_nxt[2] = fatal_nxt[2] || thermistor_open_i;
        fatal_nxt[2] = fatal_nxt[2] || exp[3];
        fatal_nxt[3] = exp[4] && !fan_rotating_i;
        fatal_nxt[4] = nvm_read_fail_i || nvm_write_fail_i;
        fatal_nxt[4] = fatal_nxt[4] || task_overflow_i;
    end

    // Fatal bits only ever set; power cycling is the only way out
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fatal_r <= 5'h0;
        end else begin
            fatal_r <= fatal_r | fatal_nxt;
        end
    end

    assign any_open = cover_front_open_i || cover_rear_open_i || cover_faceup_open_i;
    assign clr_exit = (front_seen_r || rear_seen_r) && !cover_front_open_i
                      && !cover_rear_open_i && !exit_sensor_i && !reg_sensor_i;

    // Cover state, edge history and the post-close check pulse
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cover_r <= 1'b0;
            chk_r <= 1'b1; // First cycle after reset is the power-on check
            front_prev_r <= 1'b0;
            reg_prev_r <= 1'b0;
        end else begin
            cover_r <= any_open;
            chk_r <= front_prev_r && !cover_front_open_i;
            front_prev_r <= cover_front_open_i;
            reg_prev_r <= reg_sensor_i;
        end
    end

    // Which cover has been opened since the last clear
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            front_seen_r <= 1'b0;
            rear_seen_r <= 1'b0;
        end else if (clr_exit) begin
            front_seen_r <= 1'b0;
            rear_seen_r <= 1'b0;
        end else begin
            front_seen_r <= front_seen_r || (cover_front_open_i && |jam_r);
            rear_seen_r <= rear_seen_r || (cover_rear_open_i && |jam_r);
        end
    end

    // Paper transit watches armed by registration sensor edges
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            custom_arm_r <= 1'b0;
            reg_arm_r <= 1'b0;
        end else begin
            if (exit_sensor_i || stop_now) begin
                custom_arm_r <= 1'b0;
            end else if (ctrl_r[`CTRL_CUSTOM_BIT] && reg_prev_r && !reg_sensor_i) begin
                custom_arm_r <= 1'b1;
            end
            if (exit_sensor_i || stop_now) begin
                reg_arm_r <= 1'b0;
            end else if (!reg_prev_r && reg_sensor_i) begin
                reg_arm_r <= 1'b1;
            end
        end
    end

    // Jam causes
    always_comb begin
        jam_set = 4'h0;
        jam_set[0] = exp[5] && !ctrl_r[`CTRL_CUSTOM_BIT];
        jam_set[0] = jam_set[0] || (chk_r && exit_sensor_i);
        jam_set[1] = exp[6];
        jam_set[2] = exp[7];
        jam_set[3] = chk_r && reg_sensor_i;
    end

    // Jam latch; a new cause wins over a clear in the same cycle
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            jam_r <= 4'h0;
        end else begin
            if (clr_exit) begin
                jam_r[1:0] <= jam_set[1:0];
            end else begin
                jam_r[1:0] <= jam_r[1:0] | jam_set[1:0];
            end
            // Registration jams clear through the front cover only
            if (clr_exit && front_seen_r) begin
                jam_r[3:2] <= jam_set[3:2];
            end else begin
                jam_r[3:2] <= jam_r[3:2] | jam_set[3:2];
            end
        end
    end

    assign fatal_any = |fatal_r;
    assign stop_now = cover_r || |jam_r;

    // Fatal shutdown waits for the running print cycle to end
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            fault_mon_pkg::RUN_S: begin
                if (fatal_any) begin
                    state_nxt = fault_mon_pkg::DRAIN_S;
                end
            end
            fault_mon_pkg::DRAIN_S: begin
                if (!print_cycle_i) begin
                    state_nxt = fault_mon_pkg::HALT_S;
                end
            end
            default: begin
                state_nxt = fault_mon_pkg::HALT_S; // Held until reset
            end
        endcase
    end

    // Shutdown state register
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= fault_mon_pkg::RUN_S;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Drive enables follow requests unless halted or stopped at once
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            motor_en_o <= 1'b0;
            scanner_en_o <= 1'b0;
            heater_en_o <= 1'b0;
        end else if (stop_now || state_r == fault_mon_pkg::HALT_S) begin
            motor_en_o <= 1'b0;
            scanner_en_o <= 1'b0;
            heater_en_o <= 1'b0;
        end else begin
            motor_en_o <= motor_req_i;
            scanner_en_o <= scanner_req_i;
            heater_en_o <= heater_req_i;
        end
    end

    // Cause code: fatal before cover before jams
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            code_o <= fault_mon_pkg::CODE_NONE;
        end else if (fatal_r[0]) begin
            code_o <= fault_mon_pkg::CODE_MAIN_MOTOR;
        end else if (fatal_r[1]) begin
            code_o <= fault_mon_pkg::CODE_SCANNER;
        end else if (fatal_r[2]) begin
            code_o <= fault_mon_pkg::CODE_FUSER;
        end else if (fatal_r[3]) begin
            code_o <= fault_mon_pkg::CODE_FAN;
        end else if (fatal_r[4]) begin
            code_o <= fault_mon_pkg::CODE_MEMORY;
        end else if (cover_r) begin
            code_o <= fault_mon_pkg::CODE_COVER;
        end else if (jam_r[0]) begin
            code_o <= fault_mon_pkg::CODE_EXIT_STD;
        end else if (jam_r[1]) begin
            code_o <= fault_mon_pkg::CODE_EXIT_CUSTOM;
        end else if (jam_r[2]) begin
            code_o <= fault_mon_pkg::CODE_REG_TO_EXIT;
        end else if (jam_r[3]) begin
            code_o <= fault_mon_pkg::CODE_REG_STUCK;
        end else begin
            code_o <= fault_mon_pkg::CODE_NONE;
        end
    end

    // One wait state keeps pready a flop output
    assign apb_acc = psel_i && penable_i && !pready_o;
    assign apb_done = psel_i && penable_i && pready_o;

    // APB answer: data and error loaded with pready
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0;
        end else begin
            pready_o <= apb_acc;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0;
            if (apb_acc) begin
                if (paddr_i == `CTRL_OFS) begin
                    prdata_o <= {29'h0, ctrl_r};
                end else if (paddr_i == `STATUS_OFS) begin
                    prdata_o <= {20'h0, state_r, jam_r, cover_r, fatal_r};
                end else if (paddr_i == `CODE_OFS) begin
                    prdata_o <= {27'h0, code_o};
                end else begin
                    pslverr_o <= 1'b1; // Unmapped address
                end
            end
        end
    end

    // Control register write
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_r <= `CTRL_RESET;
        end else if (apb_done && pwrite_i && paddr_i == `CTRL_OFS) begin
            ctrl_r <= pwdata_i[2:0];
        end
    end

    AST_MOTOR: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        exp[0] && !motor_at_speed_i |=> fatal_r[0]) else $error("motor fault missed");
    AST_DRAIN: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        fatal_any && !print_cycle_i |-> ##[1:3] !motor_en_o && !scanner_en_o && !heater_en_o)
        else $error("drives not stopped after fatal fault");
    AST_STICKY: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        fatal_r[2] |=> fatal_r[2] && code_o != fault_mon_pkg::CODE_NONE)
        else $error("fatal fault released");
    AST_BD_LOCKED: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        scanner_req_i && bd_lock_r && bd_cnt_r > BD_LIMIT |=> fatal_r[1])
        else $error("beam spacing fault missed");
    AST_OVERTEMP: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        fuser_temp_i > `FUSER_HIGH_DEGC |=> fatal_r[2]) else $error("overtemp missed");
    AST_COVER: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        any_open |=> cover_r) else $error("cover code missed");
    AST_STOP: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        any_open |-> ##2 !motor_en_o && !heater_en_o) else $error("no immediate stop");
    AST_NVM: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        nvm_write_fail_i |=> fatal_r[4] ##1 code_o != fault_mon_pkg::CODE_NONE)
        else $error("memory fault missed");
    AST_EXIT_CHK: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        chk_r && exit_sensor_i |=> jam_r[0]) else $error("exit check jam missed");

    COV_HALT: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        state_r == fault_mon_pkg::DRAIN_S ##1 state_r == fault_mon_pkg::HALT_S);
    COV_JAM_CLEAR: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        jam_r[0] ##1 !jam_r[0]);
    COV_APB_WRITE: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
        apb_done && pwrite_i);
endmodule
`default_nettype wire

// ===== tb/engine_model.sv
// Far-side model: polygon beam-detect pulse source and fan feedback
`timescale 1ns/100ps
`default_nettype none
module engine_model (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic run_i,
    input wire logic fan_stall_i,
    input wire logic [7:0] period_i,
    output logic beam_o,
    output logic fan_o
);
    logic [7:0] cnt_r; // Cycles since the last pulse
    // One pulse a period while spinning; silent when stopped
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_r <= 8'h00;
            beam_o <= 1'b0;
        end else begin
            cnt_r <= (!run_i || cnt_r + 8'h01 >= period_i) ? 8'h00 : cnt_r + 8'h01;
            beam_o <= run_i && cnt_r + 8'h01 >= period_i;
        end
    end
    // A stalled fan drops its rotation feedback
    assign fan_o = !fan_stall_i;
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the engine fault monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
    logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, period = 8'd15;
    logic [31:0] pwdata = 32'h0, rd;
    logic print_cycle = 1'b0, motor_req = 1'b0, scanner_req = 1'b0, heater_req = 1'b0;
    logic cover_front = 1'b0, exit_s = 1'b0, reg_s = 1'b0, er;
    logic engine_ready = 1'b0, at_speed = 1'b0, laser_ok = 1'b0;
    logic [7:0] temp = 8'hb4; // Fuser temperature in degrees C
    logic [8:0] cause = 9'h000; // One-hot single-cause stimulus
    logic [31:0] prdata;
    logic pready, pslverr, beam, fan, motor_en, scanner_en, heater_en;
    logic [4:0] code;
    int bad_count = 0, compares = 0, cyc = 0;
    // Shortened limits for the run; the waits below are sized from them
    localparam int unsigned SHORT_LIM = 30, LONG_LIM = 40, LASER_LIM = 20;
    localparam int unsigned BD_TGT = 20, BD_LIM = 30, BD_STA = 60;
    // Expected code for each entry of cause
    logic [4:0] tab [9] = '{5'h04, 5'h06, 5'h06, 5'h06, 5'h10, 5'h10, 5'h05, 5'h04, 5'h02};
    always #50 clk = ~clk;
    engine_model partner (.clk_sys_i(clk), .resetn_i(resetn), .run_i(scanner_req),
        .fan_stall_i(cause[6]), .period_i(period), .beam_o(beam), .fan_o(fan));
    fault_monitor #(.MOTOR_CYC(SHORT_LIM), .WARMUP_CYC(LONG_LIM), .HEATER_CYC(SHORT_LIM),
        .LASER_CYC(LASER_LIM), .FAN_CYC(LONG_LIM), .EXIT_CYC(SHORT_LIM),
        .CUSTOM_CYC(SHORT_LIM), .REG_CYC(SHORT_LIM), .BD_TARGET(BD_TGT),
        .BD_LIMIT(BD_LIM), .BD_START(BD_STA)) dut (
        .clk_sys_i(clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .print_cycle_i(print_cycle),
        .engine_ready_i(engine_ready), .motor_req_i(motor_req), .motor_at_speed_i(at_speed),
        .scanner_req_i(scanner_req), .beam_detect_pulse_i(beam), .laser_on_i(cause[8]),
        .laser_power_ok_i(laser_ok), .heater_req_i(heater_req),
        .fuser_temp_i(temp), .thermistor_open_i(cause[0]),
        .fan_rotating_i(fan), .nvm_read_fail_i(cause[1]), .nvm_write_fail_i(cause[2]),
        .task_overflow_i(cause[3]), .cover_front_open_i(cover_front),
        .cover_rear_open_i(cause[4]), .cover_faceup_open_i(cause[5]),
        .reg_sensor_i(reg_s), .exit_sensor_i(exit_s), .motor_en_o(motor_en),
        .scanner_en_o(scanner_en), .heater_en_o(heater_en), .code_o(code));
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Hang guard: the whole sequence needs under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    // Power cycle: the only way fatal faults clear; paper sensors and front cover left as set
    task automatic rst();
        @(posedge clk);
        resetn <= 1'b0;
        cause <= '0;
        print_cycle <= 1'b0;
        motor_req <= 1'b0;
        scanner_req <= 1'b0;
        heater_req <= 1'b0;
        engine_ready <= 1'b0;
        at_speed <= 1'b0;
        laser_ok <= 1'b0;
        temp <= 8'hb4;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
    endtask
    // APB transfer; holds everything until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No cycle count assumed; only the hang guard ends this wait
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Wait a bounded time for a code, then compare it
    task automatic expect_code(input logic [4:0] e, input int n);
        int i;
        i = 0;
        while (code !== e && i < n) begin
            @(negedge clk);
            i++;
        end
        `CHK("code", e, code)
    endtask
    // Front cover open then closed, with the paper path clear
    task automatic cover_cycle();
        @(posedge clk);
        exit_s <= 1'b0;
        reg_s <= 1'b0;
        cover_front <= 1'b1;
        repeat (3) @(posedge clk);
        cover_front <= 1'b0;
    endtask
    task automatic t_regs();
        rst();
        apb(1'b0, 8'h00, 32'h0);
        `CHK("ctrl", 32'h0, rd)
        apb(1'b1, 8'h00, 32'h2);
        apb(1'b0, 8'h00, 32'h0);
        `CHK("ctrl", 32'h2, rd)
        apb(1'b0, 8'h0c, 32'h0);
        `CHK("slverr", 1'b1, er)
        heater_req <= 1'b1;
        motor_req <= 1'b1;
        at_speed <= 1'b1; // Motor at speed: its slow-start watch must stay quiet
        expect_code(5'h04, 45);
        apb(1'b0, 8'h08, 32'h0);
        `CHK("code reg", 32'h4, rd)
        $display("test regs done");
    endtask
    task automatic t_motor();
        rst();
        print_cycle <= 1'b1;
        motor_req <= 1'b1;
        repeat (25) @(negedge clk);
        `CHK("early code", 5'h00, code)
        expect_code(5'h01, 20);
        repeat (4) @(negedge clk);
        `CHK("motor mid cycle", 1'b1, motor_en)
        @(posedge clk);
        print_cycle <= 1'b0;
        repeat (4) @(negedge clk);
        `CHK("motor stopped", 1'b0, motor_en)
        `CHK("heater stopped", 1'b0, heater_en)
        repeat (40) @(negedge clk);
        `CHK("latched", 5'h01, code)
        $display("test motor done");
    endtask
    task automatic t_scan();
        rst();
        scanner_req <= 1'b1;
        cause[8] <= 1'b1;
        laser_ok <= 1'b1; // Laser on at full power: no scanner fault from it
        repeat (120) @(negedge clk);
        `CHK("locked code", 5'h00, code)
        period <= 8'd40;
        expect_code(5'h02, 60);
        rst();
        period <= 8'd80;
        scanner_req <= 1'b1;
        expect_code(5'h02, 90);
        period <= 8'd15;
        $display("test scanner done");
    endtask
    task automatic t_jam();
        rst();
        motor_req <= 1'b1;
        engine_ready <= 1'b1; // Engine ready, so the motor watch stays idle
        repeat (3) @(posedge clk);
        exit_s <= 1'b1;
        expect_code(5'h11, 45);
        `CHK("motor at jam", 1'b0, motor_en)
        cover_cycle();
        expect_code(5'h00, 10);
        $display("test jam done");
    endtask
    // Paper left on a sensor when power comes up
    task automatic t_stuck(input bit ex);
        @(posedge clk);
        exit_s <= ex;
        reg_s <= !ex;
        rst();
        expect_code(ex ? 5'h11 : 5'h14, 5);
        cover_cycle();
        expect_code(5'h00, 10);
        $display("test stuck done");
    endtask
    task automatic t_causes();
        for (int i = 0; i < 9; i++) begin
            rst();
            cause[i] <= 1'b1;
            if (i == 7) begin
                temp <= 8'he1; // Over-temperature entry
            end
            expect_code(tab[i], 60);
        end
        $display("test causes done");
    endtask
    // Cold fuser during warm-up, then a cool fuser while printing
    task automatic t_fuser();
        rst();
        temp <= 8'h64;
        apb(1'b1, 8'h00, 32'h1);
        repeat (30) @(negedge clk);
        `CHK("warm-up early", 5'h00, code)
        expect_code(5'h04, 20);
        rst();
        temp <= 8'h78;
        print_cycle <= 1'b1;
        expect_code(5'h04, 5);
        $display("test fuser done");
    endtask
    // Sheet stuck past registration, then custom sheet missing the exit
    task automatic t_paper();
        rst();
        @(posedge clk);
        reg_s <= 1'b1;
        expect_code(5'h13, 45);
        cover_cycle();
        expect_code(5'h00, 10);
        apb(1'b1, 8'h00, 32'h4);
        reg_s <= 1'b1;
        repeat (3) @(posedge clk);
        exit_s <= 1'b1; // Leading edge passes, clearing the registration watch
        @(posedge clk);
        exit_s <= 1'b0;
        reg_s <= 1'b0;
        expect_code(5'h12, 45);
        cover_cycle();
        expect_code(5'h00, 10);
        $display("test paper done");
    endtask
    initial begin
        rst();
        t_regs();
        t_motor();
        t_scan();
        t_jam();
        t_stuck(1'b1);
        t_stuck(1'b0);
        t_fuser();
        t_paper();
        t_causes();
        tally_and_finish();
    end
endmodule
`default_nettype wire
